// ==== verilog/tshm_pkg.sv ====

package tshm_pkg;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam int unsigned ADDR_W   = 4;
  localparam logic [3:0]  CTRL_OFS = 4'h0;
  localparam logic [3:0]  HUNT_OFS = 4'h1;
  localparam logic [3:0]  MASK_OFS = 4'h2;
  localparam logic [3:0]  STAT_OFS = 4'h3;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [7:0]  CTRL_RST = 8'h00;
  localparam logic [7:0]  HUNT_RST = 8'h7e;
  localparam logic [7:0]  MASK_RST = 8'h00;

  // ----------------------------------------------------------------------
  // Field layouts, most significant bit first
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic highway_enable;
    logic transparent_select;
    logic match_enable;
    logic octet_align_select;
    logic tx_bit_order_select;
    logic rx_bit_order_select;
    logic rx_enable;
    logic tx_enable;
  } tshm_ctrl_t;

  typedef struct packed {
    logic loading;
    logic hunting;
  } tshm_stat_t;

  typedef struct packed {
    tshm_ctrl_t ctrl;
    logic [7:0] hunt;
    logic [7:0] mask;
  } tshm_cfg_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [7:0]        wdata;
    logic              wr;
    logic              rd;
  } tshm_bus_req_t;

  // ----------------------------------------------------------------------
  // Receive hunt states
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    RX_IDLE = 2'b00,
    RX_HUNT = 2'b01,
    RX_LOAD = 2'b10
  } tshm_rx_st_t;

  localparam logic [2:0] LAST_BIT = 3'h7;

endpackage

// ==== verilog/tshm_core.sv ====
// The implementer's own choices: the strobed register port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none

module tshm_core (
  // System clock and reset
  input  wire logic                  clock,
  input  wire logic                  arst_n,
  // Register port
  input  wire tshm_pkg::tshm_bus_req_t bus_req,
  output var  logic [7:0]            rd_data,
  // Receive FIFO load path
  output var  logic                  rx_fifo_load,
  output var  logic [7:0]            rx_fifo_byte,
  // Serial highway, on the link clock
  input  wire logic                  link_clock,
  input  wire logic                  slot_start,
  input  wire logic                  rx_serial,
  input  wire logic [7:0]            tx_byte,
  output var  logic                  tx_byte_take,
  output var  logic                  txd,
  output var  logic                  txd_oe
);
  import tshm_pkg::*;

  // ----------------------------------------------------------------------
  // State types
  // ----------------------------------------------------------------------
  typedef struct packed {
    tshm_cfg_t        cfg;
    logic             cfg_tog;
    logic [2:0]       rx_sync;
    logic             rx_acc;
    tshm_stat_t [2:0] stat_sync;
    tshm_stat_t       stat;
    logic [7:0]       rd_data;
    logic             fifo_load;
    logic [7:0]       fifo_byte;
  } tshm_sys_st_t;

  typedef struct packed {
    tshm_cfg_t   cfg;
    logic [2:0]  cfg_sync;
    logic        cfg_acc;
    logic [2:0]  bit_cnt;
    logic        in_slot;
    logic [2:0]  rx_cnt;
    logic [7:0]  rx_sh;
    tshm_rx_st_t rx_st;
    logic        rx_tog;
    logic [7:0]  rx_byte;
    tshm_stat_t  stat;
    logic [7:0]  tx_sh;
    logic        txd;
    logic        txd_oe;
    logic        tx_take;
  } tshm_link_st_t;

  tshm_sys_st_t  sq;
  tshm_sys_st_t  sn;
  tshm_link_st_t lq;
  tshm_link_st_t ln;

  // ----------------------------------------------------------------------
  // System domain: register port and receive byte hand-off
  // ----------------------------------------------------------------------
  always_comb begin
    sn           = sq;
    sn.rd_data   = 8'h00;
    sn.fifo_load = 1'b0;

    // Every accepted write flips the toggle, so the link side recaptures
    // the whole configuration as one word and never sees a torn mix.
    if (bus_req.wr) begin
      case (bus_req.addr)
        CTRL_OFS: begin
          sn.cfg.ctrl = tshm_ctrl_t'(bus_req.wdata);
          sn.cfg_tog  = ~sq.cfg_tog;
        end
        HUNT_OFS: begin
          sn.cfg.hunt = bus_req.wdata;
          sn.cfg_tog  = ~sq.cfg_tog;
        end
        MASK_OFS: begin
          sn.cfg.mask = bus_req.wdata;
          sn.cfg_tog  = ~sq.cfg_tog;
        end
        default: begin
        end
      endcase
    end

    // Unmapped addresses read as zero.
    if (bus_req.rd) begin
      case (bus_req.addr)
        CTRL_OFS: sn.rd_data = sq.cfg.ctrl;
        HUNT_OFS: sn.rd_data = sq.cfg.hunt;
        MASK_OFS: sn.rd_data = sq.cfg.mask;
        STAT_OFS: sn.rd_data = {6'h00, sq.stat};
        default:  sn.rd_data = 8'h00;
      endcase
    end

    // Receive byte event: toggle through three flops, counted once the
    // second and third agree. The byte itself is held steady on the link
    // side for a whole byte time, far longer than the crossing takes.
    sn.rx_sync = {sq.rx_sync[1:0], lq.rx_tog};
    if ((sq.rx_sync[1] == sq.rx_sync[2]) && (sq.rx_sync[2] != sq.rx_acc)) begin
      sn.rx_acc    = sq.rx_sync[2];
      sn.fifo_load = 1'b1;
      sn.fifo_byte = lq.rx_byte;
    end

    // Hunt status levels, same three-flop treatment.
    sn.stat_sync = {sq.stat_sync[1:0], lq.stat};
    if (sq.stat_sync[1] == sq.stat_sync[2]) begin
      sn.stat = sq.stat_sync[2];
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      sq           <= '0;
      sq.cfg.ctrl  <= tshm_ctrl_t'(CTRL_RST);
      sq.cfg.hunt  <= HUNT_RST;
      sq.cfg.mask  <= MASK_RST;
    end else begin
      sq <= sn;
    end
  end

  // ----------------------------------------------------------------------
  // Link domain: slot timing, hunt and transmit masking
  // ----------------------------------------------------------------------
  logic       hwy;
  logic       act;
  logic [2:0] pos;
  logic [2:0] tx_idx;
  logic [7:0] tx_cur;
  logic [7:0] win;
  logic       byte_end;
  logic       hit;

  always_comb begin
    ln         = lq;
    ln.tx_take = 1'b0;
    hwy        = lq.cfg.ctrl.highway_enable;
    act        = 1'b0;
    pos        = 3'h0;
    tx_idx     = 3'h0;
    tx_cur     = lq.tx_sh;
    win        = 8'h00;
    byte_end   = 1'b0;
    hit        = 1'b0;

    // Configuration word crossing: toggle through three flops.
    ln.cfg_sync = {lq.cfg_sync[1:0], sq.cfg_tog};
    if ((lq.cfg_sync[1] == lq.cfg_sync[2]) && (lq.cfg_sync[2] != lq.cfg_acc)) begin
      ln.cfg_acc = lq.cfg_sync[2];
      ln.cfg     = sq.cfg;
    end

    // Bit time within the slot. Off the highway the counter free-runs
    // and every bit time is ours.
    if (hwy && slot_start) begin
      pos = 3'h0;
    end else begin
      pos = lq.bit_cnt + 3'h1;
    end
    act        = !hwy || slot_start || (lq.in_slot && (lq.bit_cnt != LAST_BIT));
    ln.in_slot = hwy && act;
    if (act) begin
      ln.bit_cnt = pos;
    end

    // Transmit. Data passes as given; any framing lives upstream.
    tx_idx = lq.cfg.ctrl.tx_bit_order_select ? (LAST_BIT - pos) : pos;
    if (act && (pos == 3'h0)) begin
      tx_cur     = tx_byte;
      ln.tx_take = lq.cfg.ctrl.tx_enable;
    end
    ln.tx_sh = tx_cur;
    // A set mask bit drives its data bit, a clear one releases the pin;
    // off the highway the mask is not looked at.
    ln.txd_oe = act && lq.cfg.ctrl.tx_enable
              && (!hwy || lq.cfg.mask[tx_idx]);
    // Data stays low while the pin is released, so a masked bit never leaks.
    ln.txd    = ln.txd_oe && tx_cur[tx_idx];

    // Receive window in byte orientation, newest bit included.
    if (lq.cfg.ctrl.rx_bit_order_select) begin
      win = {lq.rx_sh[6:0], rx_serial};
    end else begin
      win = {rx_serial, lq.rx_sh[7:1]};
    end
    byte_end = hwy ? (pos == LAST_BIT) : (lq.rx_cnt == LAST_BIT);

    if (!(lq.cfg.ctrl.rx_enable && lq.cfg.ctrl.transparent_select)) begin
      ln.rx_st  = RX_IDLE;
      ln.rx_cnt = 3'h0;
    end else if (ln.cfg_acc != lq.cfg_acc) begin
      // Any fresh configuration re-arms the hunt.
      ln.rx_st  = RX_IDLE;
      ln.rx_cnt = 3'h0;
    end else begin
      unique case (lq.rx_st)
        RX_IDLE: begin
          ln.rx_cnt = 3'h0;
          ln.rx_sh  = 8'h00;
          if (lq.cfg.ctrl.match_enable) begin
            ln.rx_st = RX_HUNT;
          end else if (!hwy || (act && byte_end)) begin
            // On the highway, unhunted bytes start on a slot boundary so they line up with slots; off it they start at once.
            ln.rx_st = RX_LOAD;
          end
        end
        RX_HUNT: begin
          if (act) begin
            ln.rx_sh  = win;
            ln.rx_cnt = lq.rx_cnt + 3'h1;
            hit = (win == lq.cfg.hunt)
                && (!lq.cfg.ctrl.octet_align_select || byte_end);
            if (hit) begin
              ln.rx_byte = win;
              ln.rx_tog  = ~lq.rx_tog;
              ln.rx_cnt  = 3'h0;
              ln.rx_st   = RX_LOAD;
            end
          end
          // Until the hit above, no byte leaves this state.
          if (!lq.cfg.ctrl.match_enable) begin
            ln.rx_st = RX_LOAD;
          end
        end
        RX_LOAD: begin
          if (act) begin
            ln.rx_sh  = win;
            ln.rx_cnt = lq.rx_cnt + 3'h1;
            if (lq.rx_cnt == LAST_BIT) begin
              ln.rx_byte = win;
              ln.rx_tog  = ~lq.rx_tog;
            end
          end
        end
        default: begin
          ln.rx_st = RX_IDLE;
        end
      endcase
    end

    ln.stat.hunting = (ln.rx_st == RX_HUNT);
    ln.stat.loading = (ln.rx_st == RX_LOAD);
  end

  // The link clock may stop between frames; state simply waits for it.
  always_ff @(posedge link_clock or negedge arst_n) begin
    if (!arst_n) begin
      lq          <= '0;
      lq.cfg.ctrl <= tshm_ctrl_t'(CTRL_RST);
      lq.cfg.hunt <= HUNT_RST;
      lq.cfg.mask <= MASK_RST;
      lq.rx_st    <= RX_IDLE;
    end else begin
      lq <= ln;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs, all straight from flops
  // ----------------------------------------------------------------------
  assign rd_data      = sq.rd_data;
  assign rx_fifo_load = sq.fifo_load;
  assign rx_fifo_byte = sq.fifo_byte;
  assign tx_byte_take = lq.tx_take;
  assign txd          = lq.txd;
  assign txd_oe       = lq.txd_oe;

endmodule

`default_nettype wire

// ==== tb/tshm_chk.sv ====
`timescale 1ns/100ps
`default_nettype none

module tshm_chk (
  // System side
  input wire logic                    clock,
  input wire logic                    arst_n,
  input wire tshm_pkg::tshm_bus_req_t bus_req,
  input wire logic [7:0]              rd_data,
  input wire logic                    rx_fifo_load,
  input wire logic [7:0]              rx_fifo_byte,
  // Link side
  input wire logic                    link_clock,
  input wire logic                    tx_byte_take,
  input wire logic                    txd,
  input wire logic                    txd_oe
);
  import tshm_pkg::*;
  // ----------------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------------
  property p_rd_idle;
    @(posedge clock) disable iff (!arst_n) !bus_req.rd |=> rd_data == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
  property p_unmap;
    @(posedge clock) disable iff (!arst_n) bus_req.rd && bus_req.addr > 4'h3 |=> rd_data == 8'h00;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_sys_rst;
    @(posedge clock) disable iff (!arst_n) $rose(arst_n) |-> !rx_fifo_load && rd_data == 8'h00;
  endproperty
  a_sys_rst: assert property (p_sys_rst) else $error("output active after reset");
  property p_load_gap;
    @(posedge clock) disable iff (!arst_n) rx_fifo_load |=> !rx_fifo_load [*8];
  endproperty
  a_load_gap: assert property (p_load_gap) else $error("loads too close");
  property p_byte_hold;
    @(posedge clock) disable iff (!arst_n) $changed(rx_fifo_byte) |-> rx_fifo_load;
  endproperty
  a_byte_hold: assert property (p_byte_hold) else $error("byte moved without load");
  property p_hiz_low;
    @(posedge link_clock) disable iff (!arst_n) !txd_oe |-> !txd;
  endproperty
  a_hiz_low: assert property (p_hiz_low) else $error("data while undriven");
  property p_take;
    @(posedge link_clock) disable iff (!arst_n) tx_byte_take |=> !tx_byte_take;
  endproperty
  a_take: assert property (p_take) else $error("take longer than one cycle");
  property p_link_rst;
    @(posedge link_clock) disable iff (!arst_n) $rose(arst_n) |-> !txd_oe && !tx_byte_take;
  endproperty
  a_link_rst: assert property (p_link_rst) else $error("pin driven after reset");
  c_load: cover property (@(posedge clock) rx_fifo_load);
  c_drive: cover property (@(posedge link_clock) tx_byte_take && txd_oe);
  c_read: cover property (@(posedge clock) bus_req.rd ##1 rd_data != 8'h00);
endmodule

bind tshm_core tshm_chk tshm_chk_i (.clock(clock), .arst_n(arst_n), .bus_req(bus_req),
  .rd_data(rd_data), .rx_fifo_load(rx_fifo_load), .rx_fifo_byte(rx_fifo_byte),
  .link_clock(link_clock), .tx_byte_take(tx_byte_take), .txd(txd), .txd_oe(txd_oe));

`default_nettype wire

// ==== tb/tshm_hwy.sv ====
`timescale 1ns/100ps
`default_nettype none

module tshm_hwy (
  // Link clock and reset
  input  wire logic        link_clock,
  input  wire logic        arst_n,
  // Bench settings
  input  wire logic        hwy,
  input  wire logic [31:0] rx_pat,
  input  wire logic [7:0]  tx_val,
  // Device pins
  input  wire logic        txd,
  input  wire logic        txd_oe,
  output var  logic        slot_start,
  output var  logic        rx_serial,
  output var  logic [7:0]  tx_byte,
  output var  logic        line
);
  logic [3:0] cnt;
  logic [1:0] sn;
  logic [4:0] ri;
  logic       last;
  // Slot bits are tied to slot number so byte boundaries never drift.
  assign slot_start = hwy && cnt == 4'h0;
  assign rx_serial  = hwy ? rx_pat[{sn, cnt[2:0]}] : rx_pat[ri];
  assign tx_byte    = tx_val;
  // An undriven highway shows the inverse of its last level, never a kind guess.
  assign line       = txd_oe ? txd : ~last;
  always_ff @(posedge link_clock or negedge arst_n) begin
    if (!arst_n) begin
      cnt  <= 4'h0;
      sn   <= 2'h0;
      ri   <= 5'h00;
      last <= 1'b0;
    end else begin
      cnt  <= cnt + 4'h1;
      ri   <= ri + 5'h01;
      last <= line;
      if (cnt == 4'h7) sn <= sn + 2'h1;
    end
  end
endmodule

`default_nettype wire

// ==== tb/tb_top.sv ====
`timescale 1ns/100ps
`default_nettype none

module tb_top;
  import tshm_pkg::*;
  logic          clock = 1'b0;
  logic          link_clock = 1'b0;
  logic          arst_n = 1'b0;
  tshm_bus_req_t bus_req = '0;
  logic [7:0]    rd_data, rx_fifo_byte, tx_byte, tx_val = 8'h00, txo, txv;
  logic          rx_fifo_load, slot_start, rx_serial, tx_byte_take, txd, txd_oe, line;
  logic          hwy = 1'b0;
  logic          rd_pend = 1'b0;
  logic [31:0]   rx_pat = 32'h0;
  logic [15:0]   rd_q[$], rx_q[$], tx_q[$];
  int            err_count = 0;
  int            checks = 0;
  int            seed = 32'hc333;

  initial forever #2.5 clock = ~clock;
  initial begin
    #1.3;
    forever #6 link_clock = ~link_clock;
  end

  tshm_core tshm_core_i (.clock(clock), .arst_n(arst_n), .bus_req(bus_req), .rd_data(rd_data),
    .rx_fifo_load(rx_fifo_load), .rx_fifo_byte(rx_fifo_byte), .link_clock(link_clock),
    .slot_start(slot_start), .rx_serial(rx_serial), .tx_byte(tx_byte),
    .tx_byte_take(tx_byte_take), .txd(txd), .txd_oe(txd_oe));
  tshm_hwy tshm_hwy_i (.link_clock(link_clock), .arst_n(arst_n), .hwy(hwy), .rx_pat(rx_pat),
    .tx_val(tx_val), .txd(txd), .txd_oe(txd_oe), .slot_start(slot_start),
    .rx_serial(rx_serial), .tx_byte(tx_byte), .line(line));

  task automatic cmp(input string n, input logic [15:0] e, input logic [15:0] g);
    checks++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic results();
    if (err_count == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Writes leave the link side time to pick up the new configuration.
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock) bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clock) bus_req <= '0;
    repeat (16) @(posedge clock);
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    rd_q.push_back({8'h00, e});
    @(posedge clock) bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clock) bus_req <= '0;
  endtask
  task automatic drain();
    int i;
    for (i = 0; i < 4000 && rx_q.size() + tx_q.size() + rd_q.size() > 0; i++) @(posedge clock);
    if (i == 4000) begin
      err_count++;
      results();
    end
  endtask
  task automatic rx_run(input logic [7:0] c, input logic [31:0] p, e, input int n);
    rx_pat <= p;
    for (int i = 0; i < n; i++) rx_q.push_back({8'h00, e[8*i +: 8]});
    wr(CTRL_OFS, c);
    if (n == 0) repeat (400) @(posedge clock);
    drain();
    wr(CTRL_OFS, 8'h00);
  endtask
  function automatic logic [15:0] tx_exp(input logic [7:0] d, m, input logic o, h);
    logic [7:0] eo, ed;
    for (int k = 0; k < 8; k++) begin
      eo[k] = h ? m[o ? 7 - k : k] : 1'b1;
      ed[k] = d[o ? 7 - k : k] & eo[k];
    end
    return {eo, ed};
  endfunction

  always @(negedge clock) begin
    if (rd_pend) cmp("rd_data", rd_q.pop_front(), {8'h00, rd_data});
    rd_pend = bus_req.rd;
    if (rx_fifo_load === 1'b1 && rx_q.size() == 0) cmp("rx_extra", 16'h0, 16'h1);
    else if (rx_fifo_load === 1'b1) cmp("rx_byte", rx_q.pop_front(), rx_fifo_byte);
  end
  always @(negedge link_clock) begin
    if (tx_byte_take === 1'b1 && tx_q.size() > 0) begin
      for (int k = 0; k < 8; k++) begin
        if (k > 0) @(negedge link_clock);
        txo[k] = txd_oe;
        txv[k] = line;
      end
      cmp("tx_slot", tx_q.pop_front(), {txo, txv & txo});
    end
  end

  initial begin
    logic [7:0] m, r0, r1, r2, r3;
    logic       o;
    repeat (2) @(posedge clock);
    arst_n <= 1'b1;
    rd(CTRL_OFS, CTRL_RST);
    rd(STAT_OFS, 8'h00);
    rd(HUNT_OFS, 8'h7e);
    rd(MASK_OFS, 8'h00);
    rd(4'hf, 8'h00);
    tx_val <= $random(seed);
    hwy    <= 1'b1;
    wr(CTRL_OFS, 8'h81);
    tx_q.push_back(tx_exp(tx_val, 8'h00, 1'b0, 1'b1));
    drain();
    for (int i = 0; i < 4; i++) begin
      m = (i < 2) ? 8'hc0 : 8'($random(seed));
      o = ~i[0];
      wr(MASK_OFS, m);
      wr(CTRL_OFS, {4'h8, o, 3'b001});
      tx_q.push_back(tx_exp(tx_val, m, o, 1'b1));
      drain();
    end
    hwy <= 1'b0;
    wr(CTRL_OFS, 8'h01);
    tx_q.push_back(tx_exp(tx_val, m, 1'b0, 1'b0));
    drain();
    // Masked random bytes hold no run of ones, so the hunt character is unique.
    r0 = $random(seed);
    r1 = $random(seed) & 8'h55;
    r2 = $random(seed) & 8'h55;
    r3 = $random(seed) & 8'h55;
    hwy <= 1'b1;
    rx_run(8'ha2, {r3, r2, r1, 8'h7e}, 32'h0, 0);
    rx_run(8'he2, {r2, r1, 8'h7e, r3} << 4 | r2 >> 4, {r3, r2, r1, 8'h7e}, 4);
    rx_run(8'hf2, {r2, r1, 8'h7e, r3} << 4 | r2 >> 4, 32'h0, 0);
    wr(HUNT_OFS, 8'h3c);
    rd(HUNT_OFS, 8'h3c);
    rx_run(8'hf2, {r3, r2, r1, 8'h3c}, {r3, r2, r1, 8'h3c}, 4);
    rx_run(8'hc2, {4{r0}}, {4{r0}}, 4);
    drain();
    results();
  end
endmodule

`default_nettype wire
